// *** include/uvd_pkg.sv ***
// Purpose: Shared constants and carriers for the vendor request and code download block
// Assumes: Setup packets arrive already decoded into eight bytes
// Notes: Codes and offsets used by the block
package uvd_pkg;
	// ----------------------------------------
	// Request codes
	// ----------------------------------------
	localparam logic [7:0] REQ_TYPE_OUT = 8'h40;
	localparam logic [7:0] REQ_TYPE_IN = 8'hc0;
	localparam logic [7:0] REQ_REGISTER = 8'ha0;
	localparam logic [7:0] REQ_FIRMWARE = 8'ha1;
	localparam logic [15:0] REG_LEN = 16'h0002;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SPACE_BIT = 15;
	localparam int RIO_GO_BIT = 15;
	localparam int RIO_WR_BIT = 14;
	localparam int CTL_READY_BIT = 0;
	localparam int CTL_DISC_BIT = 1;
	localparam int CTL_BOOT_BIT = 2;
	// ----------------------------------------
	// Controller space map
	// ----------------------------------------
	localparam logic [14:0] MCU_CTL = 15'h0000;
	localparam logic [14:0] MCU_DL1 = 15'h0001;
	localparam logic [14:0] MCU_DL2 = 15'h0002;
	localparam logic [14:0] MCU_DL3 = 15'h0003;
	localparam logic [14:0] MCU_CFG = 15'h0004;
	localparam logic [14:0] MCU_EP_READY = 15'h0005;
	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [2:0] CTL_RESET = 3'h0;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam int EP0_MAXPKT = 8;
	localparam int DISC_NS = 10000;
	localparam int CLK_NS = 10;
	localparam int DISC_CYCLES = DISC_NS / CLK_NS;

	typedef struct packed {
		logic [7:0] req_type;
		logic [7:0] request;
		logic [15:0] value;
		logic [15:0] index;
		logic [15:0] length;
	} uvd_setup_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
		logic wr;
	} uvd_dsp_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WDATA = 3'b001,
		ST_DSP_WAIT = 3'b010,
		ST_RDATA = 3'b011,
		ST_FW = 3'b100,
		ST_STATUS = 3'b101
	} uvd_state_t;
endpackage : uvd_pkg

// *** design/uvd_core.sv ***
// Purpose: Vendor requests on the control endpoint and bulk program download to the DSP
// Assumes: Bytes from the USB engine are on CLK; DSP access done pulses on CLK
// Notes: Register port reaches both the controller space and the DSP space
// How it works
// RULE1: Write request is type 40, code a0, address in value, index 0, length 2.
// RULE2: Read request is type c0, code a0, address in value, index 0, length 2.
// RULE3: Address bit 15 high picks controller space, low picks DSP space.
// RULE4: DSP read launches address with bit 15 set, bit 14 clear.
// RULE5: DSP write loads data first, then address with bits 15 and 14 set.
// RULE6: Read is setup, IN data stage with value, then status.
// RULE7: Firmware request type 40 code a1 writes bytes at incrementing address.
// RULE8: Bulk endpoints 1 to 3 download program, each with own address.
// RULE9: Endpoint downloads run independently and never touch each other.
// RULE10: Each endpoint address advances automatically as code arrives.
// RULE11: Four byte groups drop the zero low byte, three bytes form one instruction.
// RULE12: Host sets download address and waits before streaming code.
// RULE13: Host lets download finish before giving a new address.
// RULE14: Code streams of any length are accepted once addresses are set.
// RULE15: Program download is offered only after re-enumeration on loaded firmware. Code gates it on the ready bit with the pullup on.
// RULE16: After attach the device is a bootstrap function with one 8 byte endpoint.
// RULE17: Configuration code is readable by a register read request.
// RULE18: Setting disconnect bit drops the bus, then reconnects with new configuration.
// RULE19: Control register holds firmware ready, disconnect and boot source bits.
// RULE20: Generic endpoints carry nothing until all their buffer registers are written.
// RULE21: Partial instruction group at end is dropped; address stays on it.
`timescale 1ns/1ps
module uvd_core #(
	parameter int NUM_EP = 3,
	parameter int DISC_CYCLES = uvd_pkg::DISC_CYCLES
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SETUP_VALID,
	input wire uvd_pkg::uvd_setup_t SETUP,
	input wire logic OUT_VALID,
	input wire logic [7:0] OUT_DATA,
	input wire logic IN_READY,
	output logic IN_VALID,
	output logic [7:0] IN_DATA,
	output logic STATUS_DONE,
	output logic STALL,
	input wire logic [NUM_EP-1:0] BULK_VALID,
	input wire logic [NUM_EP-1:0] BULK_LAST,
	input wire logic [7:0] BULK_DATA [NUM_EP],
	output logic [NUM_EP-1:0] BULK_ACCEPT,
	output logic [NUM_EP-1:0] PM_WE,
	output logic [15:0] PM_ADDR [NUM_EP],
	output logic [23:0] PM_DATA [NUM_EP],
	output logic DSP_GO,
	output uvd_pkg::uvd_dsp_t DSP_REQ,
	input wire logic DSP_DONE,
	input wire logic [15:0] DSP_RDATA,
	output logic FW_WE,
	output logic [15:0] FW_ADDR,
	output logic [7:0] FW_DATA,
	input wire logic [15:0] CFG_CODE,
	input wire logic [7:0] EP_SETUP_WRITTEN,
	output logic [7:0] EP_ENABLE,
	output logic PULLUP_EN,
	output logic [7:0] EP0_MAXPKT,
	output logic RAM_FIRMWARE,
	output logic [2:0] CTL
);
	uvd_pkg::uvd_state_t state;
	logic [15:0] req_addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic byte_sel;
	logic [2:0] ctl;
	logic [15:0] dl_addr [NUM_EP];
	logic [15:0] disc_cnt;
	logic [7:0] ep_written;
	logic ldr_valid;
	logic is_wr_req;
	logic is_rd_req;
	logic is_fw_req;
	logic [14:0] mcu_a;
	logic [15:0] fw_left;
	logic in_primed;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	assign is_wr_req = SETUP.req_type == uvd_pkg::REQ_TYPE_OUT && SETUP.request == uvd_pkg::REQ_REGISTER
		&& SETUP.index == 16'h0000 && SETUP.length == uvd_pkg::REG_LEN; // [RULE1]
	assign is_rd_req = SETUP.req_type == uvd_pkg::REQ_TYPE_IN && SETUP.request == uvd_pkg::REQ_REGISTER
		&& SETUP.index == 16'h0000 && SETUP.length == uvd_pkg::REG_LEN; // [RULE2]
	assign is_fw_req = SETUP.req_type == uvd_pkg::REQ_TYPE_OUT && SETUP.request == uvd_pkg::REQ_FIRMWARE; // [RULE7]
	assign mcu_a = req_addr[14:0];
	assign ldr_valid = ctl[uvd_pkg::CTL_READY_BIT] && PULLUP_EN;

	// ----------------------------------------
	// Control transfer sequencer
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= uvd_pkg::ST_IDLE;
			req_addr <= uvd_pkg::ADDR_RESET;
			wdata <= 16'h0000;
			rdata <= 16'h0000;
			fw_left <= 16'h0000;
			byte_sel <= 1'b0;
			STALL <= 1'b0;
		end else begin
			STALL <= 1'b0;
			case (state)
				uvd_pkg::ST_IDLE: begin
					byte_sel <= 1'b0;
					if (SETUP_VALID) begin
						req_addr <= SETUP.value;
						if (is_wr_req) begin
							state <= uvd_pkg::ST_WDATA;
						end else if (is_fw_req) begin
							state <= (SETUP.length == 16'h0000) ? uvd_pkg::ST_STATUS : uvd_pkg::ST_FW; // [RULE7]
							fw_left <= SETUP.length;
						end else if (is_rd_req) begin
							if (SETUP.value[uvd_pkg::SPACE_BIT]) begin // [RULE3]
								state <= uvd_pkg::ST_RDATA;
							end else begin
								state <= uvd_pkg::ST_DSP_WAIT;
							end
						end else begin
							STALL <= 1'b1;
						end
					end
				end
				uvd_pkg::ST_WDATA: begin
					if (OUT_VALID) begin
						byte_sel <= 1'b1;
						if (!byte_sel) begin
							wdata[7:0] <= OUT_DATA;
						end else begin
							wdata[15:8] <= OUT_DATA;
							state <= req_addr[uvd_pkg::SPACE_BIT] ? uvd_pkg::ST_STATUS : uvd_pkg::ST_DSP_WAIT; // [RULE3]
						end
					end
				end
				uvd_pkg::ST_DSP_WAIT: begin
					if (DSP_DONE) begin
						rdata <= DSP_RDATA; // [RULE4]
						byte_sel <= 1'b0;
						state <= DSP_REQ.wr ? uvd_pkg::ST_STATUS : uvd_pkg::ST_RDATA;
					end
				end
				uvd_pkg::ST_RDATA: begin
					if (IN_VALID && IN_READY) begin
						byte_sel <= 1'b1;
						if (byte_sel) begin
							state <= uvd_pkg::ST_STATUS; // [RULE6]
						end
					end
				end
				uvd_pkg::ST_FW: begin
					if (SETUP_VALID) begin
						state <= uvd_pkg::ST_STATUS;
					end else if (OUT_VALID) begin
						req_addr <= req_addr + 16'h0001; // [RULE7]
						fw_left <= fw_left - 16'h0001;
						if (fw_left == 16'h0001) begin
							state <= uvd_pkg::ST_STATUS; // [RULE7]
						end
					end
				end
				uvd_pkg::ST_STATUS: state <= uvd_pkg::ST_IDLE;
				default: state <= uvd_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read data path
	// ----------------------------------------
	logic [15:0] mcu_rd;
	always_comb begin
		mcu_rd = 16'h0000;
		case (mcu_a)
			uvd_pkg::MCU_CTL: mcu_rd = {13'h0000, ctl};
			uvd_pkg::MCU_DL1: mcu_rd = dl_addr[0];
			uvd_pkg::MCU_DL2: mcu_rd = (NUM_EP > 1) ? dl_addr[NUM_EP > 1 ? 1 : 0] : 16'h0000;
			uvd_pkg::MCU_DL3: mcu_rd = (NUM_EP > 2) ? dl_addr[NUM_EP > 2 ? 2 : 0] : 16'h0000;
			uvd_pkg::MCU_CFG: mcu_rd = CFG_CODE; // [RULE17]
			uvd_pkg::MCU_EP_READY: mcu_rd = {8'h00, EP_ENABLE};
			default: mcu_rd = 16'h0000;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			IN_DATA <= 8'h00;
			in_primed <= 1'b0;
		end else begin
			// Byte register needs one cycle after each handshake to settle
			in_primed <= state == uvd_pkg::ST_RDATA && !(IN_VALID && IN_READY);
			IN_DATA <= byte_sel ? (req_addr[uvd_pkg::SPACE_BIT] ? mcu_rd[15:8] : rdata[15:8])
				: (req_addr[uvd_pkg::SPACE_BIT] ? mcu_rd[7:0] : rdata[7:0]);
		end
	end
	assign IN_VALID = state == uvd_pkg::ST_RDATA && in_primed; // [RULE6]
	assign STATUS_DONE = state == uvd_pkg::ST_STATUS;

	// ----------------------------------------
	// DSP register access launch
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			DSP_GO <= 1'b0;
			DSP_REQ <= '0;
		end else begin
			DSP_GO <= 1'b0;
			if (state == uvd_pkg::ST_IDLE && SETUP_VALID && is_rd_req && !SETUP.value[uvd_pkg::SPACE_BIT]) begin
				DSP_REQ.addr <= {1'b1, 1'b0, SETUP.value[13:0]}; // [RULE4]
				DSP_REQ.wr <= 1'b0;
				DSP_GO <= 1'b1;
			end else if (state == uvd_pkg::ST_WDATA && OUT_VALID && byte_sel && !req_addr[uvd_pkg::SPACE_BIT]) begin
				DSP_REQ.data <= {OUT_DATA, wdata[7:0]}; // [RULE5]
				DSP_REQ.addr <= {1'b1, 1'b1, req_addr[13:0]}; // [RULE5]
				DSP_REQ.wr <= 1'b1;
				DSP_GO <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Firmware byte writes
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			FW_WE <= 1'b0;
			FW_ADDR <= 16'h0000;
			FW_DATA <= 8'h00;
		end else begin
			FW_WE <= state == uvd_pkg::ST_FW && OUT_VALID && !SETUP_VALID; // [RULE7]
			FW_ADDR <= req_addr;
			FW_DATA <= OUT_DATA;
		end
	end

	// ----------------------------------------
	// Control register and re-enumeration
	// ----------------------------------------
	logic mcu_wr;
	assign mcu_wr = state == uvd_pkg::ST_WDATA && OUT_VALID && byte_sel && req_addr[uvd_pkg::SPACE_BIT];

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctl <= uvd_pkg::CTL_RESET;
			disc_cnt <= 16'h0000;
			PULLUP_EN <= 1'b1;
		end else begin
			if (mcu_wr && mcu_a == uvd_pkg::MCU_CTL) begin
				ctl <= wdata[2:0]; // [RULE19]
			end
			if (ctl[uvd_pkg::CTL_DISC_BIT] && PULLUP_EN) begin
				PULLUP_EN <= 1'b0; // [RULE18]
				disc_cnt <= 16'(DISC_CYCLES);
			end else if (!PULLUP_EN) begin
				if (disc_cnt == 16'h0001) begin
					PULLUP_EN <= 1'b1; // [RULE18]
					ctl[uvd_pkg::CTL_DISC_BIT] <= 1'b0;
				end
				disc_cnt <= disc_cnt - 16'h0001;
			end
		end
	end
	assign CTL = ctl;
	assign RAM_FIRMWARE = ctl[uvd_pkg::CTL_BOOT_BIT];
	assign EP0_MAXPKT = 8'(uvd_pkg::EP0_MAXPKT); // [RULE16]

	// ----------------------------------------
	// Generic endpoint enables
	// ----------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ep_written <= 8'h00;
		end else if (!PULLUP_EN) begin
			ep_written <= 8'h00;
		end else begin
			ep_written <= ep_written | EP_SETUP_WRITTEN;
		end
	end
	assign EP_ENABLE = ldr_valid ? ep_written : 8'h00; // [RULE20]

	// ----------------------------------------
	// Per endpoint program loaders
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++) begin : gen_ep
			logic [1:0] cnt;
			logic [23:0] word;
			logic set_addr;
			assign set_addr = mcu_wr && mcu_a == 15'(g + 1);
			assign BULK_ACCEPT[g] = ldr_valid; // [RULE15]
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					cnt <= 2'h0;
					word <= 24'h000000;
					dl_addr[g] <= uvd_pkg::ADDR_RESET;
					PM_WE[g] <= 1'b0;
					PM_ADDR[g] <= 16'h0000;
					PM_DATA[g] <= 24'h000000;
				end else begin
					PM_WE[g] <= 1'b0;
					if (set_addr) begin
						dl_addr[g] <= {OUT_DATA, wdata[7:0]}; // [RULE8]
						cnt <= 2'h0;
					end else if (BULK_VALID[g] && ldr_valid) begin // [RULE9] [RULE14]
						cnt <= cnt + 2'h1;
						case (cnt)
							2'h0: word[23:16] <= BULK_DATA[g];
							2'h1: word[15:8] <= BULK_DATA[g];
							2'h2: word[7:0] <= BULK_DATA[g];
							default: begin
								PM_WE[g] <= 1'b1; // [RULE11]
								PM_ADDR[g] <= dl_addr[g];
								PM_DATA[g] <= word;
								dl_addr[g] <= dl_addr[g] + 16'h0001; // [RULE10]
							end
						endcase
						if (BULK_LAST[g] && cnt != 2'h3) begin
							cnt <= 2'h0; // [RULE21]
						end
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	dsp_read_launch_a: assert property (@(posedge CLK) disable iff (RST) // [RULE4]
		state == uvd_pkg::ST_IDLE && SETUP_VALID && is_rd_req && !SETUP.value[15]
		|=> DSP_GO && DSP_REQ.addr[15] && !DSP_REQ.addr[14]) else $error("dsp read launch wrong");
	dsp_write_launch_a: assert property (@(posedge CLK) disable iff (RST) // [RULE5]
		DSP_GO && DSP_REQ.wr |-> DSP_REQ.addr[15] && DSP_REQ.addr[14]) else $error("dsp write launch wrong");
	space_select_a: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
		state == uvd_pkg::ST_IDLE && SETUP_VALID && is_rd_req && SETUP.value[15]
		|=> state == uvd_pkg::ST_RDATA) else $error("controller read went to dsp");
	read_stage_a: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
		state == uvd_pkg::ST_RDATA && byte_sel && IN_VALID && IN_READY |=> STATUS_DONE)
		else $error("no status after read");
	fw_incr_a: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
		state == uvd_pkg::ST_FW && OUT_VALID && !SETUP_VALID |=> FW_WE && req_addr == $past(req_addr) + 16'h0001)
		else $error("firmware address not advanced");
	gate_load_a: assert property (@(posedge CLK) disable iff (RST) // [RULE15]
		!ldr_valid |=> PM_WE == '0) else $error("download before firmware ready");
	disc_drop_a: assert property (@(posedge CLK) disable iff (RST) // [RULE18]
		ctl[1] && PULLUP_EN |=> !PULLUP_EN) else $error("no disconnect");
	ep_gate_a: assert property (@(posedge CLK) disable iff (RST) // [RULE20]
		(EP_ENABLE & ~ep_written) == 8'h00) else $error("endpoint enabled before setup");
	bad_req_a: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
		state == uvd_pkg::ST_IDLE && SETUP_VALID && !is_wr_req && !is_rd_req && !is_fw_req |=> STALL)
		else $error("bad request not stalled");
endmodule : uvd_core

// *** verif/uvd_dsp_model.sv ***
// Purpose: Register side of the DSP behind the block
// Assumes: One access at a time
// Notes: Latency cycles 0 to 3; data line toggles when idle
`timescale 1ns/1ps
module uvd_dsp_model (
	input wire logic CLK,
	input wire logic RST,
	input wire logic DSP_GO,
	input wire uvd_pkg::uvd_dsp_t DSP_REQ,
	output logic DSP_DONE,
	output logic [15:0] DSP_RDATA
);
	logic [15:0] mem [16384];
	uvd_pkg::uvd_dsp_t req;
	logic [1:0] lat;
	logic [1:0] cnt;
	logic busy;
	logic fin;
	assign fin = busy && cnt == 2'd0;
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy <= 1'b0;
			cnt <= 2'd0;
			lat <= 2'd0;
			req <= '0;
			DSP_DONE <= 1'b0;
			DSP_RDATA <= 16'h5a5a;
		end else begin
			DSP_DONE <= fin;
			if (fin && !req.wr) DSP_RDATA <= mem[req.addr[13:0]];
			else DSP_RDATA <= ~DSP_RDATA;
			if (fin && req.wr) mem[req.addr[13:0]] <= req.data;
			busy <= DSP_GO || (busy && !fin);
			cnt <= DSP_GO ? lat : cnt - 2'd1;
			lat <= DSP_GO ? lat + 2'd1 : lat;
			if (DSP_GO) req <= DSP_REQ;
		end
	end
endmodule : uvd_dsp_model

// *** verif/uvd_tb_top.sv ***
// Purpose: Self-checking bench for vendor requests and code download
// Assumes: Disconnect time cut to 4 cycles
// Notes: Random data from a fixed xorshift seed
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; $display("ERROR t=%0t %h %h", $time, a, e); end end
module usb_vendor_request_and_code_download_tb_top;
	logic CLK, RST, SETUP_VALID, OUT_VALID, IN_READY, DSP_DONE, IN_VALID, STATUS_DONE, STALL, DSP_GO, FW_WE;
	logic PULLUP_EN, RAM_FIRMWARE, ld, st, dn;
	uvd_pkg::uvd_setup_t SETUP;
	uvd_pkg::uvd_dsp_t DSP_REQ, dq;
	logic [7:0] OUT_DATA, IN_DATA, FW_DATA, EP_SETUP_WRITTEN, EP_ENABLE, EP0_MAXPKT;
	logic [2:0] BULK_VALID, BULK_LAST, BULK_ACCEPT, PM_WE, CTL;
	logic [7:0] BULK_DATA [3];
	logic [15:0] PM_ADDR [3];
	logic [23:0] PM_DATA [3];
	logic [15:0] DSP_RDATA, FW_ADDR, CFG_CODE, rv, a, d, fw_a;
	logic [15:0] dla [3];
	logic [39:0] pe;
	logic [39:0] pq [3][$];
	logic [7:0] ob [$];
	logic [7:0] ib [$];
	logic [31:0] seed;
	int failures, compares, low_n, fw_i;
	uvd_core #(.NUM_EP(3), .DISC_CYCLES(4)) i_uvd_core (.CLK(CLK), .RST(RST), .SETUP_VALID(SETUP_VALID),
		.SETUP(SETUP), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .IN_READY(IN_READY), .IN_VALID(IN_VALID),
		.IN_DATA(IN_DATA), .STATUS_DONE(STATUS_DONE), .STALL(STALL), .BULK_VALID(BULK_VALID), .BULK_LAST(BULK_LAST),
		.BULK_DATA(BULK_DATA), .BULK_ACCEPT(BULK_ACCEPT), .PM_WE(PM_WE), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
		.DSP_GO(DSP_GO), .DSP_REQ(DSP_REQ), .DSP_DONE(DSP_DONE), .DSP_RDATA(DSP_RDATA), .FW_WE(FW_WE),
		.FW_ADDR(FW_ADDR), .FW_DATA(FW_DATA), .CFG_CODE(CFG_CODE), .EP_SETUP_WRITTEN(EP_SETUP_WRITTEN),
		.EP_ENABLE(EP_ENABLE), .PULLUP_EN(PULLUP_EN), .EP0_MAXPKT(EP0_MAXPKT), .RAM_FIRMWARE(RAM_FIRMWARE), .CTL(CTL));
	uvd_dsp_model i_uvd_dsp_model (.CLK(CLK), .RST(RST), .DSP_GO(DSP_GO), .DSP_REQ(DSP_REQ), .DSP_DONE(DSP_DONE),
		.DSP_RDATA(DSP_RDATA));
	// ----
	// Helpers
	// ----
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] gbyte(input logic [23:0] ins, input int k);
		return (k == 3) ? 8'h00 : 8'(ins >> (16 - 8 * k));
	endfunction : gbyte
	task automatic give_verdict();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic xfer(input logic [7:0] t, input logic [7:0] r, input logic [15:0] v, input logic [15:0] len);
		int k;
		ib.delete();
		st = 1'b0;
		dn = 1'b0;
		k = 0;
		@(posedge CLK);
		SETUP_VALID <= 1'b1;
		SETUP <= {t, r, v, 16'h0000, len};
		for (int i = 0; i < 200; i++) begin
			@(posedge CLK);
			SETUP_VALID <= 1'b0;
			OUT_VALID <= (k < ob.size());
			if (k < ob.size()) OUT_DATA <= ob[k];
			k++;
			if (IN_VALID === 1'b1) ib.push_back(IN_DATA);
			st = (STALL === 1'b1);
			dn = (STATUS_DONE === 1'b1);
			if (st || dn) break;
		end
		if (!(st || dn)) begin
			failures++;
			give_verdict();
		end
	endtask : xfer
	task automatic wr(input logic [15:0] ad, input logic [15:0] dt);
		ob = '{dt[7:0], dt[15:8]};
		xfer(uvd_pkg::REQ_TYPE_OUT, uvd_pkg::REQ_REGISTER, ad, uvd_pkg::REG_LEN);
	endtask : wr
	task automatic rd(input logic [15:0] ad);
		ob.delete();
		xfer(uvd_pkg::REQ_TYPE_IN, uvd_pkg::REQ_REGISTER, ad, uvd_pkg::REG_LEN);
		rv = {ib[1], ib[0]};
	endtask : rd
	task automatic bulk(input int ng);
		int idx [3];
		logic [23:0] ins [3];
		idx = '{0, 0, 0};
		for (int c = 0; c < 300 && idx.sum() < 3 * (4 * ng + 2); c++) begin
			@(posedge CLK);
			for (int e = 0; e < 3; e++) begin
				if (idx[e] < 4 * ng + 2 && rnd() % 3 != 0) begin
					if (idx[e] % 4 == 0) ins[e] = 24'(rnd());
					BULK_VALID[e] <= 1'b1;
					BULK_LAST[e] <= (idx[e] == 4 * ng + 1);
					BULK_DATA[e] <= gbyte(ins[e], idx[e] % 4);
					if (ld && idx[e] % 4 == 3) begin
						pq[e].push_back({dla[e], ins[e]});
						dla[e]++;
					end
					idx[e]++;
				end else begin
					BULK_VALID[e] <= 1'b0;
					BULK_LAST[e] <= 1'b0;
				end
			end
		end
		@(posedge CLK);
		BULK_VALID <= 3'h0;
		BULK_LAST <= 3'h0;
		repeat (3) @(posedge CLK);
		`CHK(BULK_ACCEPT, {3{ld}})
		for (int e = 0; e < 3; e++) `CHK(pq[e].size(), 0)
	endtask : bulk
	// ----
	// Monitors
	// ----
	always @(posedge CLK) begin
		if (!RST && PULLUP_EN === 1'b0) low_n++;
		if (DSP_GO === 1'b1) dq = DSP_REQ;
		if (FW_WE === 1'b1) begin
			`CHK({FW_ADDR, FW_DATA}, {16'(fw_a + fw_i), ob[fw_i]})
			fw_i++;
		end
		for (int e = 0; e < 3; e++) begin
			if (PM_WE[e] === 1'b1) begin
				pe = (pq[e].size() > 0) ? pq[e].pop_front() : 'x;
				`CHK({PM_ADDR[e], PM_DATA[e]}, pe)
			end
		end
	end
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	initial begin
		#900000;
		failures++;
		give_verdict();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		seed = 32'd75520;
		RST = 1'b1;
		SETUP_VALID = 1'b0;
		SETUP = '0;
		OUT_VALID = 1'b0;
		OUT_DATA = 8'h00;
		IN_READY = 1'b1;
		BULK_VALID = 3'h0;
		BULK_LAST = 3'h0;
		BULK_DATA = '{8'h00, 8'h00, 8'h00};
		EP_SETUP_WRITTEN = 8'h00;
		CFG_CODE = 16'(rnd());
		fw_i = 0;
		fw_a = 16'h0000;
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		`CHK({PULLUP_EN, EP0_MAXPKT}, {1'b1, 8'h08})
		`CHK({RAM_FIRMWARE, CTL}, 4'h0)
		`CHK(EP_ENABLE, 8'h00)
		EP_SETUP_WRITTEN <= 8'h05;
		ld = 1'b0;
		bulk(2);
		`CHK(EP_ENABLE, 8'h00)
		$display("test locked_before_ready done");
		wr(16'h8000, 16'h0005);
		`CHK({RAM_FIRMWARE, CTL}, 4'hd)
		rd(16'h8000);
		`CHK(rv, 16'h0005)
		rd(16'h8004);
		`CHK(rv, CFG_CODE)
		rd(16'h8005);
		`CHK(rv, 16'h0005)
		$display("test controller_space done");
		for (int i = 0; i < 4; i++) begin
			a = {2'b00, 14'(rnd())};
			d = 16'(rnd());
			wr(a, d);
			`CHK(dq, {a | 16'hc000, d, 1'b1})
			rd(a);
			`CHK({dq.addr, dq.wr}, {a | 16'h8000, 1'b0})
			`CHK(rv, d)
		end
		$display("test dsp_space done");
		for (int i = 0; i < 3; i++) begin
			ob.delete();
			xfer(i == 0 ? 8'h41 : 8'h40, i == 1 ? 8'h55 : 8'ha0, 16'h8000, i == 2 ? 16'h0003 : 16'h0002);
			`CHK(st, 1'b1)
		end
		`CHK(CTL, 3'h5)
		$display("test refused_setup done");
		ld = 1'b1;
		for (int e = 0; e < 3; e++) begin
			dla[e] = 16'(rnd());
			wr(16'h8001 + 16'(e), dla[e]);
		end
		bulk(3);
		bulk(2);
		$display("test bulk_download done");
		ob.delete();
		for (int i = 0; i < 5; i++) ob.push_back(8'(rnd()));
		fw_a = 16'(rnd());
		xfer(uvd_pkg::REQ_TYPE_OUT, uvd_pkg::REQ_FIRMWARE, fw_a, 16'h0005);
		@(posedge CLK);
		`CHK(fw_i, 5)
		$display("test firmware_download done");
		low_n = 0;
		wr(16'h8000, 16'h0003);
		for (int i = 0; i < 50 && !(low_n > 0 && PULLUP_EN === 1'b1); i++) @(posedge CLK);
		`CHK(low_n >= 4, 1'b1)
		`CHK(CTL, 3'h1)
		$display("test reenumerate done");
		give_verdict();
	end
endmodule : usb_vendor_request_and_code_download_tb_top
